// *** src/ulpi_timing_pkg.sv ***
package ulpi_timing_pkg;

  // ----------------------------------------
  // Clock and bus timing
  // ----------------------------------------
  localparam int CLK_PS = 40000;
  localparam int FS_BIT_PS = 83333;
  // Full-speed bit time in clock cycles, rounded up so the gap is never short
  localparam int FS_BIT_CYC = (FS_BIT_PS + CLK_PS - 1) / CLK_PS;
  localparam int PRE_HDR_BITS = 16;
  localparam int PRE_GAP_BITS = 4;
  localparam logic [7:0] PRE_HDR_CYC = 8'(PRE_HDR_BITS * FS_BIT_CYC);
  localparam logic [7:0] PRE_GAP_CYC = 8'(PRE_GAP_BITS * FS_BIT_CYC);

  // Overheads: pin path (two sync flops, output flop), same-domain path (output flop)
  localparam int PIN_OVH = 3;
  localparam int LOC_OVH = 1;

  // ----------------------------------------
  // Pipeline delays, in interface clock cycles
  // ----------------------------------------
  localparam int RXCMD_JK_CYC = 4;
  localparam int RXCMD_SE0_HS_CYC = 4;
  localparam int RXCMD_SE0_FS_CYC = 5;
  localparam int RXCMD_SE0_LS_CYC = 17;
  localparam int TX_START_HS_CYC = 2;
  localparam int TX_START_FS_CYC = 8;
  localparam int TX_START_LS_CYC = 75;
  localparam int TX_END_PKT_CYC = 4;
  localparam int TX_END_SOF_CYC = 8;
  localparam int TX_END_FSLS_CYC = 2;
  localparam int RX_START_HS_CYC = 6;
  localparam int RX_START_FSLS_CYC = 4;
  localparam int RX_END_HS_CYC = 6;
  localparam int RX_END_FS_CYC = 18;
  localparam int RX_END_LS_CYC = 123;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] FUNCTION_CONTROL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam int FC_XCVR_LSB = 0;
  localparam int FC_TERM_BIT = 2;
  localparam int FC_OPMODE_LSB = 3;
  localparam int FC_SUSPENDM_BIT = 6;
  localparam logic [31:0] FUNCTION_CONTROL_RST = 32'h0000_0041;
  localparam logic [1:0] LINE_SE0 = 2'h0;
  // Pin flops start at the idle levels (line J, no sync, no EOP) so reset makes no edge
  localparam logic [3:0] PIN_RST = 4'h1;

  typedef enum logic [1:0] {SPD_HS, SPD_FS, SPD_LS, SPD_PRE} speed_t;

  // Pin-path count: total delay less the synchroniser and detect overhead
  function automatic logic [7:0] pin_cnt(input int cyc);
    return 8'(cyc - PIN_OVH);
  endfunction

  function automatic logic [7:0] loc_cnt(input int cyc);
    return 8'(cyc - LOC_OVH);
  endfunction

  // Line-change report delay; J/K is speed independent, SE0 is not
  function automatic logic [7:0] rxcmd_cnt(input speed_t spd, input logic se0);
    if (!se0) begin
      return pin_cnt(RXCMD_JK_CYC);
    end
    unique case (spd)
      SPD_HS: return pin_cnt(RXCMD_SE0_HS_CYC);
      SPD_LS: return pin_cnt(RXCMD_SE0_LS_CYC);
      default: return pin_cnt(RXCMD_SE0_FS_CYC);
    endcase
  endfunction

  // Preamble packets go out at low-speed rate after the header
  function automatic logic [7:0] tx_start_cnt(input speed_t spd);
    unique case (spd)
      SPD_HS: return loc_cnt(TX_START_HS_CYC);
      SPD_LS: return loc_cnt(TX_START_LS_CYC);
      default: return loc_cnt(TX_START_FS_CYC);
    endcase
  endfunction

  function automatic logic [7:0] rx_end_cnt(input speed_t spd);
    unique case (spd)
      SPD_HS: return pin_cnt(RX_END_HS_CYC);
      SPD_FS: return pin_cnt(RX_END_FS_CYC);
      default: return pin_cnt(RX_END_LS_CYC);
    endcase
  endfunction

endpackage

// *** src/delay_if.sv ***
`timescale 1ns/100ps
// Start/count/done handshake between a user and one delay timer
interface delay_if;
  logic start;
  logic [7:0] count;
  logic done;
  logic busy;
  modport timer (input start, input count, output done, output busy);
  modport user (output start, output count, input done, input busy);
endinterface

// *** src/delay_timer.sv ***
`timescale 1ns/100ps
// Load on start, pulse done exactly count cycles after the start edge
module delay_timer (
  input wire logic clk,
  input wire logic reset,
  delay_if.timer dl
);
  logic [7:0] cnt_q;
  logic done_q;

  // Countdown; a new start restarts the count, so the latest event wins
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_q <= 8'h00;
    end else if (dl.start) begin
      cnt_q <= dl.count;
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end

  // Done pulse on the last count
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      done_q <= 1'b0;
    end else begin
      done_q <= !dl.start && (cnt_q == 8'h01);
    end
  end

  assign dl.done = done_q;
  assign dl.busy = (cnt_q != 8'h00);
endmodule // delay_timer

// *** src/ulpi_chirp_packet_timing.sv ***
// Contract
// - Line changes reported 4 cycles later; SE0 delay depends on speed.
// - Transmit start and high-speed transmit end latencies per speed.
// - Receive start and end latencies per speed.
// - Speed select 11b is preamble mode: full-speed edges, low-speed receive.
// - Preamble mode sends full-speed header before each low-speed packet.
// - After header, drive J one bit; gap of four bits before SYNC (the code drives J for the whole four-bit gap).
// - Clearing suspend-not bit puts transceiver into low-power state.
`timescale 1ns/100ps
module ulpi_chirp_packet_timing (
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Line receiver (asynchronous pins)
  input wire logic [1:0] line_state,
  input wire logic rx_sync_seen,
  input wire logic rx_eop_seen,
  // Link transmit requests (same clock)
  input wire logic tx_cmd,
  input wire logic tx_sof,
  input wire logic tx_stop,
  // Reports and bus activity
  output logic rxcmd_valid,
  output logic [1:0] rxcmd_line,
  output logic rx_active,
  output logic bus_tx_start,
  output logic bus_tx_end,
  output logic pre_header,
  output logic pre_drive_j,
  output logic ls_rate,
  output logic fs_edges,
  output logic term_select,
  output logic [1:0] opmode,
  output logic low_power
);

  // ----------------------------------------
  // Timers
  // ----------------------------------------
  localparam int T_RXCMD = 0;
  localparam int T_TXS = 1;
  localparam int T_TXE = 2;
  localparam int T_RXS = 3;
  localparam int T_RXE = 4;
  localparam int T_PRE = 5;
  localparam int N_TIMERS = 6;

  delay_if tm[N_TIMERS] ();

  // One countdown per event stream so overlapping packets never share a count
  generate
    for (genvar i = 0; i < N_TIMERS; i++) begin : g_tm
      delay_timer u_tm (
        .clk(clk),
        .reset(reset),
        .dl(tm[i])
      );
    end
  endgenerate

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [31:0] fn_control_q;
  logic [31:0] reg_rdata_q;
  ulpi_timing_pkg::speed_t speed;
  logic suspendm;
  logic low_power_q;
  logic rx_active_q;
  logic pre_busy;

  assign speed = ulpi_timing_pkg::speed_t'(fn_control_q[ulpi_timing_pkg::FC_XCVR_LSB +: 2]);
  assign suspendm = fn_control_q[ulpi_timing_pkg::FC_SUSPENDM_BIT];

  // Function control write; only bits 6:0 are kept
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fn_control_q <= ulpi_timing_pkg::FUNCTION_CONTROL_RST;
    end else if (reg_wr && reg_addr == ulpi_timing_pkg::FUNCTION_CONTROL_OFS) begin
      fn_control_q <= {25'h0000000, reg_wdata[6:0]};
    end
  end

  // Read data one cycle after the strobe; unmapped addresses read zero
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rdata_q <= 32'h0000_0000;
    end else if (reg_rd && reg_addr == ulpi_timing_pkg::FUNCTION_CONTROL_OFS) begin
      reg_rdata_q <= fn_control_q;
    end else if (reg_rd && reg_addr == ulpi_timing_pkg::STATUS_OFS) begin
      reg_rdata_q <= {26'h0000000, low_power_q, pre_busy, tm[T_TXE].busy, rx_active_q, speed};
    end else begin
      reg_rdata_q <= 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // Mode outputs to the analog front end
  // ----------------------------------------
  logic term_select_q;
  logic [1:0] opmode_q;
  logic fs_edges_q;

  // Preamble keeps full-speed edge rates; suspend-not cleared drops to low power
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      term_select_q <= 1'b0;
      opmode_q <= 2'h0;
      low_power_q <= 1'b0;
      fs_edges_q <= 1'b0;
    end else begin
      term_select_q <= fn_control_q[ulpi_timing_pkg::FC_TERM_BIT];
      opmode_q <= fn_control_q[ulpi_timing_pkg::FC_OPMODE_LSB +: 2];
      low_power_q <= !suspendm;
      fs_edges_q <= (speed != ulpi_timing_pkg::SPD_HS);
    end
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [3:0] prev_q;
  logic line_change;
  logic sync_rise;
  logic eop_rise;

  // Two flops before any logic; prev_q holds the last settled value for edges
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync1_q <= ulpi_timing_pkg::PIN_RST;
      sync2_q <= ulpi_timing_pkg::PIN_RST;
      prev_q <= ulpi_timing_pkg::PIN_RST;
    end else begin
      sync1_q <= {rx_eop_seen, rx_sync_seen, line_state};
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  assign line_change = (sync2_q[1:0] != prev_q[1:0]) && suspendm;
  assign sync_rise = sync2_q[2] && !prev_q[2] && suspendm;
  assign eop_rise = sync2_q[3] && !prev_q[3] && suspendm;

  // ----------------------------------------
  // Line state reports
  // ----------------------------------------
  logic [1:0] pend_line_q;
  logic rxcmd_valid_q;
  logic [1:0] rxcmd_line_q;

  assign tm[T_RXCMD].start = line_change;
  assign tm[T_RXCMD].count = ulpi_timing_pkg::rxcmd_cnt(speed,
    sync2_q[1:0] == ulpi_timing_pkg::LINE_SE0);

  // A change inside the window restarts it, so only the latest state is sent
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pend_line_q <= 2'h0;
      rxcmd_valid_q <= 1'b0;
      rxcmd_line_q <= 2'h0;
    end else begin
      if (line_change) begin
        pend_line_q <= sync2_q[1:0];
      end
      rxcmd_valid_q <= tm[T_RXCMD].done;
      if (tm[T_RXCMD].done) begin
        rxcmd_line_q <= pend_line_q;
      end
    end
  end

  // ----------------------------------------
  // Receive path
  // ----------------------------------------
  assign tm[T_RXS].start = sync_rise;
  assign tm[T_RXS].count = (speed == ulpi_timing_pkg::SPD_HS) ?
    ulpi_timing_pkg::pin_cnt(ulpi_timing_pkg::RX_START_HS_CYC) :
    ulpi_timing_pkg::pin_cnt(ulpi_timing_pkg::RX_START_FSLS_CYC);
  assign tm[T_RXE].start = eop_rise;
  assign tm[T_RXE].count = ulpi_timing_pkg::rx_end_cnt(speed);

  // Start wins over end in the same cycle so a packet one cycle behind is kept
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_active_q <= 1'b0;
    end else if (tm[T_RXS].done) begin
      rx_active_q <= 1'b1;
    end else if (tm[T_RXE].done) begin
      rx_active_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Transmit path and preamble sequencing
  // ----------------------------------------
  typedef enum logic [2:0] {PRE_IDLE, PRE_HDR, PRE_GAP, PRE_LS} pre_state_t;
  pre_state_t pre_state_q;
  logic tx_go;
  logic sof_q;
  logic bus_tx_start_q;
  logic bus_tx_end_q;
  logic pre_header_q;
  logic pre_drive_j_q;
  logic ls_rate_q;

  assign pre_busy = (pre_state_q != PRE_IDLE);
  assign tx_go = tx_cmd && suspendm;
  assign tm[T_TXS].start = tx_go;
  assign tm[T_TXS].count = ulpi_timing_pkg::tx_start_cnt(speed);
  assign tm[T_TXE].start = tx_stop && suspendm;
  assign tm[T_TXE].count = (speed != ulpi_timing_pkg::SPD_HS) ?
    ulpi_timing_pkg::loc_cnt(ulpi_timing_pkg::TX_END_FSLS_CYC) :
    sof_q ? ulpi_timing_pkg::loc_cnt(ulpi_timing_pkg::TX_END_SOF_CYC) :
    ulpi_timing_pkg::loc_cnt(ulpi_timing_pkg::TX_END_PKT_CYC);
  assign tm[T_PRE].start = (pre_state_q == PRE_IDLE && tm[T_TXS].done &&
    speed == ulpi_timing_pkg::SPD_PRE) || (pre_state_q == PRE_HDR && tm[T_PRE].done);
  assign tm[T_PRE].count = (pre_state_q == PRE_IDLE) ?
    ulpi_timing_pkg::PRE_HDR_CYC - 8'h01 : ulpi_timing_pkg::PRE_GAP_CYC - 8'h01;

  // Packet kind is captured with the command so a late flag change cannot alter it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sof_q <= 1'b0;
    end else if (tx_go) begin
      sof_q <= tx_sof;
    end
  end

  // Header at full-speed rate, then J and gap, then the packet at low-speed rate
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pre_state_q <= PRE_IDLE;
    end else begin
      unique case (pre_state_q)
        PRE_IDLE: if (tm[T_PRE].start) begin
          pre_state_q <= PRE_HDR;
        end
        PRE_HDR: if (tm[T_PRE].done) begin
          pre_state_q <= PRE_GAP;
        end
        PRE_GAP: if (tm[T_PRE].done) begin
          pre_state_q <= PRE_LS;
        end
        PRE_LS: if (tm[T_TXE].done) begin
          pre_state_q <= PRE_IDLE;
        end
        default: pre_state_q <= PRE_IDLE;
      endcase
    end
  end

  // Bus activity flags, all registered
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bus_tx_start_q <= 1'b0;
      bus_tx_end_q <= 1'b0;
      pre_header_q <= 1'b0;
      pre_drive_j_q <= 1'b0;
      ls_rate_q <= 1'b0;
    end else begin
      bus_tx_start_q <= (tm[T_TXS].done && speed != ulpi_timing_pkg::SPD_PRE) ||
        (pre_state_q == PRE_GAP && tm[T_PRE].done);
      bus_tx_end_q <= tm[T_TXE].done;
      pre_header_q <= tm[T_PRE].start ? (pre_state_q == PRE_IDLE) :
        (pre_state_q == PRE_HDR);
      pre_drive_j_q <= (pre_state_q == PRE_HDR && tm[T_PRE].done) ||
        (pre_state_q == PRE_GAP && !tm[T_PRE].done);
      ls_rate_q <= (pre_state_q == PRE_GAP && tm[T_PRE].done) ||
        (pre_state_q == PRE_LS && !tm[T_TXE].done) ||
        (speed == ulpi_timing_pkg::SPD_LS);
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign reg_rdata = reg_rdata_q;
  assign rxcmd_valid = rxcmd_valid_q;
  assign rxcmd_line = rxcmd_line_q;
  assign rx_active = rx_active_q;
  assign bus_tx_start = bus_tx_start_q;
  assign bus_tx_end = bus_tx_end_q;
  assign pre_header = pre_header_q;
  assign pre_drive_j = pre_drive_j_q;
  assign ls_rate = ls_rate_q;
  assign fs_edges = fs_edges_q;
  assign term_select = term_select_q;
  assign opmode = opmode_q;
  assign low_power = low_power_q;

endmodule // ulpi_chirp_packet_timing

// *** tb/ulpi_chirp_packet_timing_props.sv ***
`timescale 1ns/100ps
// ------
// Port-level timing checks
// ------
module ulpi_chirp_packet_timing_props (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [1:0] line_state,
  input wire logic tx_cmd,
  input wire logic tx_stop,
  input wire logic rxcmd_valid,
  input wire logic [1:0] rxcmd_line,
  input wire logic bus_tx_start,
  input wire logic bus_tx_end,
  input wire logic pre_header,
  input wire logic pre_drive_j,
  input wire logic fs_edges,
  input wire logic term_select,
  input wire logic [1:0] opmode,
  input wire logic low_power
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // Control writes; the copies land two samples later, one for the register, one for the output
  logic ctrl_wr;
  assign ctrl_wr = reg_wr && reg_addr == ulpi_timing_pkg::FUNCTION_CONTROL_OFS;

  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  a_ctrl_upper: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata[31:7] == 25'h0)
    else $error("control upper bits not zero");
  a_unmapped_zero: assert property (reg_rd && reg_addr != 8'h00 && reg_addr != 8'h04
    |=> reg_rdata == 32'h0) else $error("unmapped read not zero");
  a_suspend_power: assert property (
    ctrl_wr |-> ##2 low_power == !$past(reg_wdata[6], 2)) else $error("low power wrong");
  a_mode_copy: assert property (ctrl_wr |-> ##2 opmode == $past(reg_wdata[4:3], 2)
    && term_select == $past(reg_wdata[2], 2)) else $error("mode copy wrong");
  a_edge_rate: assert property (
    ctrl_wr |-> ##2 fs_edges == ($past(reg_wdata[1:0], 2) != 2'h0)) else $error("edge rate");
  a_tx_start_hs: assert property (
    tx_cmd && !fs_edges && !low_power |-> ##1 !bus_tx_start [*2] ##1 bus_tx_start)
    else $error("high-speed tx start latency");
  a_tx_end_fs: assert property (
    tx_stop && fs_edges && !low_power |-> ##1 !bus_tx_end [*2] ##1 bus_tx_end)
    else $error("full-speed tx end latency");
  a_line_report: assert property (
    rxcmd_valid && rxcmd_line != 2'h0 |-> rxcmd_line == $past(line_state, 5))
    else $error("line report value or delay");
  a_report_once: assert property (rxcmd_valid |=> !rxcmd_valid)
    else $error("report longer than one cycle");
  a_pre_order: assert property (
    $fell(pre_header) |-> pre_drive_j && !bus_tx_start) else $error("no J after header");
  a_asleep_quiet: assert property (
    tx_cmd && low_power |-> ##1 !bus_tx_start [*8]) else $error("tx while asleep");
endmodule // ulpi_chirp_packet_timing_props

bind ulpi_chirp_packet_timing ulpi_chirp_packet_timing_props u_props (
  .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .line_state(line_state), .tx_cmd(tx_cmd),
  .tx_stop(tx_stop), .rxcmd_valid(rxcmd_valid), .rxcmd_line(rxcmd_line),
  .bus_tx_start(bus_tx_start), .bus_tx_end(bus_tx_end), .pre_header(pre_header),
  .pre_drive_j(pre_drive_j), .fs_edges(fs_edges), .term_select(term_select),
  .opmode(opmode), .low_power(low_power)
);

// *** tb/link_model.sv ***
`timescale 1ns/100ps
// ------
// Link-side master: register port and transmit requests
// ------
module link_model (
  input wire logic clk,
  input wire logic [31:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  output logic tx_cmd,
  output logic tx_sof,
  output logic tx_stop
);
  // Quiet bus from time zero
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd, tx_cmd, tx_sof, tx_stop} = '0;
  end

  // One strobe cycle, all timing in interface clocks
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Data stands only in the cycle after the strobe, so it is taken mid-cycle there
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask

  // Packet start or stop request; mode writes happen before it
  // Requests are spaced by the bench past each latency window
  task automatic pulse(input logic stop, input logic sof);
    @(posedge clk);
    tx_cmd <= !stop;
    tx_stop <= stop;
    tx_sof <= sof;
    @(posedge clk);
    tx_cmd <= 1'b0;
    tx_stop <= 1'b0;
  endtask
endmodule // link_model

// *** tb/test_ulpi_chirp_packet_timing.sv ***
`timescale 1ns/100ps
module test_ulpi_chirp_packet_timing;
  logic clk, reset, reg_wr, reg_rd, tx_cmd, tx_sof, tx_stop, rx_sync_seen, rx_eop_seen;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rv;
  logic [1:0] line_state, rxcmd_line, opmode;
  logic rxcmd_valid, rx_active, bus_tx_start, bus_tx_end, pre_header, pre_drive_j;
  logic ls_rate, fs_edges, term_select, low_power, ra_q;
  logic [1:0] lv[3] = '{2'h2, 2'h0, 2'h1};
  int err_count, num_checks, cyc, t0, t_rx, t_ts, t_te, t_ra, n_rx, n_hdr, n_j;

  ulpi_chirp_packet_timing DUT (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .line_state(line_state),
    .rx_sync_seen(rx_sync_seen), .rx_eop_seen(rx_eop_seen), .tx_cmd(tx_cmd),
    .tx_sof(tx_sof), .tx_stop(tx_stop), .rxcmd_valid(rxcmd_valid), .rxcmd_line(rxcmd_line),
    .rx_active(rx_active), .bus_tx_start(bus_tx_start), .bus_tx_end(bus_tx_end),
    .pre_header(pre_header), .pre_drive_j(pre_drive_j), .ls_rate(ls_rate),
    .fs_edges(fs_edges), .term_select(term_select), .opmode(opmode), .low_power(low_power)
  );
  link_model lm (
    .clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .tx_cmd(tx_cmd), .tx_sof(tx_sof), .tx_stop(tx_stop)
  );

  // 25 MHz interface clock and a cycle count for time stamps
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  // Stamp events mid-cycle, where outputs have settled
  always @(negedge clk) begin
    if (rxcmd_valid === 1'b1) begin
      t_rx = cyc;
      n_rx++;
    end
    if (bus_tx_start === 1'b1) t_ts = cyc;
    if (bus_tx_end === 1'b1) t_te = cyc;
    if (rx_active !== ra_q) t_ra = cyc;
    ra_q = rx_active;
    n_hdr += (pre_header === 1'b1);
    n_j += (pre_drive_j === 1'b1);
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Stamp distance for a delay figure: one extra cycle for the capture edge
  function automatic int lat(input int k, input int s);
    int t[6][4] = '{'{4, 4, 4, 4}, '{4, 5, 17, 5}, '{6, 4, 4, 4}, '{6, 18, 123, 123},
      '{2, 8, 75, 8}, '{4, 2, 2, 2}};
    return t[k][s] + 1;
  endfunction

  // Change the receiver pins; t0 is taken at the capture edge
  // Pin changes stand for far-side chirps, SE0 and packets
  task automatic pin(input logic [1:0] v, input logic s, input logic e);
    @(posedge clk);
    line_state <= v;
    rx_sync_seen <= s;
    rx_eop_seen <= e;
    @(posedge clk);
    t0 = cyc;
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // A hang is cut short well beyond the roughly one thousand cycles the run needs
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    print_verdict();
  end

  initial begin
    rv = $urandom(57911);
    reset = 1'b1;
    line_state = 2'h1;
    rx_sync_seen = 1'b0;
    rx_eop_seen = 1'b0;
    {cyc, err_count, num_checks, n_rx, n_hdr, n_j, t_ts} = '0;
    ra_q = 1'b0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    // Reset values, unmapped place, read-only upper bits, suspend
    lm.rd(8'h00, rv);
    check(rv, 32'h41);
    lm.rd(8'h04, rv);
    check(rv, 32'h01);
    lm.wr(8'h08, 32'hFFFF_FFFF);
    lm.rd(8'h08, rv);
    check(rv, 32'h0);
    lm.wr(8'h00, 32'hFFFF_FF81);
    lm.rd(8'h00, rv);
    check(rv, 32'h01);
    lm.rd(8'h04, rv);
    check(rv, 32'h21);
    n_rx = 0;
    pin(2'h2, 1'b0, 1'b0);
    lm.pulse(1'b0, 1'b0);
    repeat (30) @(posedge clk);
    check(n_rx, 0);
    check(t_ts, 0);
    pin(2'h1, 1'b0, 1'b0);
    // Chirp setup, then normal high speed, then full-speed idle termination
    lm.wr(8'h00, 32'h0000_0050);
    repeat (3) @(posedge clk);
    check({opmode, term_select, fs_edges}, 4'h8);
    lm.wr(8'h00, 32'h0000_0040);
    repeat (3) @(posedge clk);
    check({opmode, term_select, fs_edges}, 4'h0);
    lm.wr(8'h00, 32'h0000_0045);
    repeat (3) @(posedge clk);
    check({opmode, term_select, fs_edges}, 4'h3);
    // Every speed, preamble last, with random mode fields and gaps
    for (int s = 0; s < 4; s++) begin
      rv = {25'h0, 2'h2, 2'($urandom_range(0, 3)), 1'($urandom_range(0, 1)), 2'(s)};
      lm.wr(8'h00, rv);
      repeat (30) @(posedge clk);
      check({opmode, term_select, fs_edges}, {rv[4:2], 1'(s != 0)});
      for (int i = 0; i < 3; i++) begin
        pin(lv[i], 1'b0, 1'b0);
        repeat (lat(lv[i] == 2'h0, s) + 2) @(posedge clk);
        check(t_rx - t0, lat(lv[i] == 2'h0, s));
      end
      pin(2'h1, 1'b1, 1'b0);
      repeat (lat(2, s) + 2) @(posedge clk);
      check(t_ra - t0, lat(2, s));
      pin(2'h1, 1'b1, 1'b1);
      repeat (lat(3, s) + 2) @(posedge clk);
      check(t_ra - t0, lat(3, s));
      pin(2'h1, 1'b0, 1'b0);
      repeat ($urandom_range(1, 5)) @(posedge clk);
      n_hdr = 0;
      n_j = 0;
      lm.pulse(1'b0, 1'b0);
      t0 = cyc;
      repeat (lat(4, s) + 2 + 80 * (s == 3)) @(posedge clk);
      if (s < 3) begin
        check(t_ts - t0, lat(4, s));
      end else begin
        check(n_hdr, ulpi_timing_pkg::PRE_HDR_CYC);
        check(n_j, ulpi_timing_pkg::PRE_GAP_CYC);
        check(ls_rate, 1'b1);
      end
      lm.pulse(1'b1, 1'b0);
      t0 = cyc;
      repeat (lat(5, s) + 2) @(posedge clk);
      check(t_te - t0, lat(5, s));
      if (s == 0) begin
        lm.pulse(1'b0, 1'b1);
        repeat (8) @(posedge clk);
        lm.pulse(1'b1, 1'b1);
        t0 = cyc;
        repeat (12) @(posedge clk);
        check(t_te - t0, ulpi_timing_pkg::TX_END_SOF_CYC + 1);
      end
    end
    // A second reset at the end of the run restores the control defaults
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    lm.rd(8'h00, rv);
    check(rv, 32'h41);
    print_verdict();
  end
endmodule // test_ulpi_chirp_packet_timing
